// File: dag_chan_addr.sv
// one general dma channel: current address stepping and end detection
`timescale 1ns/100ps
`include "dag_consts.svh"
module dag_chan_addr
   import dag_pkg::*;
(
   input  wire logic          clk_i,
   input  wire logic          rst_b_i,
   input  wire dag_chan_cfg_t cfg_i,
   input  wire logic          start_wr_i,
   input  wire logic          done_i,
   output logic [11:0]        cur_addr_o,
   output logic               last_o,
   output logic               stop_o
);
   logic [11:0] cur_reg;
   logic [11:0] cur_next;

   // end hit judged on address in use, before stepping
   assign last_o     = (cur_reg == cfg_i.end_addr);
   assign cur_addr_o = cur_reg;
   assign stop_o     = done_i && last_o && !cfg_i.loop;

   // next current address
   always_comb begin
      cur_next = cur_reg;
      if (start_wr_i) begin
         cur_next = cfg_i.start_addr;
      end else if (done_i && last_o) begin
         cur_next = cfg_i.start_addr;
      end else if (done_i) begin
         cur_next = cur_reg + (cfg_i.word ? `DAG_STEP_WORD
                                          : `DAG_STEP_BYTE);
      end
   end

   // register current address
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cur_reg <= 12'h000;
      end else begin
         cur_reg <= cur_next;
      end
   end

   chk_step_size: assert property (
      @(posedge clk_i) disable iff (!rst_b_i)
      done_i && !last_o && !start_wr_i |=> cur_reg == $past(cur_reg) +
         ($past(cfg_i.word) ? `DAG_STEP_WORD : `DAG_STEP_BYTE))
      else $error("current address step wrong");
   chk_end_reload: assert property (
      @(posedge clk_i) disable iff (!rst_b_i)
      done_i && last_o && !start_wr_i |=> cur_reg == $past(cfg_i.start_addr))
      else $error("no reload after end address");
endmodule : dag_chan_addr

// File: dag_consts.svh
// register offsets, field positions and constants for dma address generation
`ifndef DAG_CONSTS_SVH
`define DAG_CONSTS_SVH
`define DAG_OFS_CH0_HIGH_NIB   12'hfb2
`define DAG_OFS_CH0_START_LOW  12'hfb3
`define DAG_OFS_CH0_END_LOW    12'hfb4
`define DAG_OFS_CH1_HIGH_NIB   12'hfba
`define DAG_OFS_CH1_START_LOW  12'hfbb
`define DAG_OFS_CH1_END_LOW    12'hfbc
`define DAG_OFS_ADC_BASE       12'hfbd
`define DAG_OFS_CH0_CTRL       12'hfb0
`define DAG_OFS_CH1_CTRL       12'hfb8
`define DAG_OFS_ADC_CTRL       12'hfbe
`define DAG_CTRL_EN_BIT        7
`define DAG_CTRL_LOOP_BIT      6
`define DAG_CTRL_WORD_BIT      3
`define DAG_ADC_EN_BIT         7
`define DAG_STEP_BYTE          12'h001
`define DAG_STEP_WORD          12'h002
`define DAG_ADC_LAST_MAX       4'hb
`define DAG_RESET_BYTE         8'h00
`endif

// File: dag_pkg.sv
// shared types for dma address generation
package dag_pkg;
   typedef struct packed {
      logic [11:0] addr;
      logic [7:0]  data;
      logic        ch;
   } dag_xfer_t;
   typedef struct packed {
      logic [11:0] start_addr;
      logic [11:0] end_addr;
      logic        en;
      logic        loop;
      logic        word;
   } dag_chan_cfg_t;
   typedef enum logic [2:0] {
      DAG_IDLE = 3'b001,
      DAG_MSB  = 3'b010,
      DAG_LSB  = 3'b100
   } dag_adc_state_t;
endpackage : dag_pkg

// File: dag_rf_sink.sv
// register-file model that takes the adc byte stream, slowly if asked
`timescale 1ns/100ps
module dag_rf_sink (
   input  wire logic        clk_i,
   input  wire logic        rst_b_i,
   input  wire logic        stall_i,
   input  wire logic [11:0] rf_addr_i,
   input  wire logic [7:0]  rf_data_i,
   input  wire logic        rf_valid_i,
   output logic             rf_ready_o
);
   logic [7:0] mem [4096];
   logic [1:0] cnt_reg;
   // free-running phase, ready only one cycle in four while stalling
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) cnt_reg <= 2'h0;
      else cnt_reg <= cnt_reg + 2'h1;
   end
   assign rf_ready_o = ~stall_i | (cnt_reg == 2'h0);
   // store each accepted byte at its address
   always_ff @(posedge clk_i) begin
      if (rf_valid_i && rf_ready_o) mem[rf_addr_i] <= rf_data_i;
   end
endmodule : dag_rf_sink

// File: dag_skid_buf.sv
// two-entry buffer with valid and ready on both sides
`timescale 1ns/100ps
module dag_skid_buf
   import dag_pkg::*;
#(
   parameter int DEPTH = 2
)(
   input  wire logic      clk_i,
   input  wire logic      rst_b_i,
   input  wire dag_xfer_t in_data_i,
   input  wire logic      in_valid_i,
   output logic           in_ready_o,
   output dag_xfer_t      out_data_o,
   output logic           out_valid_o,
   input  wire logic      out_ready_i
);
   // one-bit pointers serve exactly two entries
   if (DEPTH != 2) begin : g_depth_check
      $error("depth must be two");
   end
   dag_xfer_t   mem_reg [DEPTH];
   dag_xfer_t   mem_next [DEPTH];
   logic        wp_reg, wp_next, rp_reg, rp_next;
   logic [1:0]  cnt_reg, cnt_next;
   logic        push, pop;

   assign in_ready_o  = (cnt_reg != 2'h2);
   assign out_valid_o = (cnt_reg != 2'h0);
   assign out_data_o  = mem_reg[rp_reg];
   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_valid_o && out_ready_i;

   // pointer, count and storage next values
   always_comb begin
      wp_next  = wp_reg ^ push;
      rp_next  = rp_reg ^ pop;
      cnt_next = cnt_reg + {1'b0, push} - {1'b0, pop};
      for (int i = 0; i < DEPTH; i++) begin
         mem_next[i] = mem_reg[i];
      end
      if (push) begin
         mem_next[wp_reg] = in_data_i;
      end
   end

   // register buffer state
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wp_reg  <= 1'b0;
         rp_reg  <= 1'b0;
         cnt_reg <= 2'h0;
         for (int i = 0; i < DEPTH; i++) begin
            mem_reg[i] <= '0;
         end
      end else begin
         wp_reg  <= wp_next;
         rp_reg  <= rp_next;
         cnt_reg <= cnt_next;
         mem_reg <= mem_next;
      end
   end
endmodule : dag_skid_buf

// File: dag_top.sv
// dma address generation: registers, two channels, adc result path
`timescale 1ns/100ps
`include "dag_consts.svh"
module dag_top
   import dag_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_b_i,
   // avalon-mm slave
   input  wire logic [11:0] avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   output logic [1:0]       avs_response,
   // channel transfer completion strobes
   input  wire logic        ch0_done_i,
   input  wire logic        ch1_done_i,
   output logic [11:0]      ch0_addr_o,
   output logic [11:0]      ch1_addr_o,
   output logic             ch0_active_o,
   output logic             ch1_active_o,
   // adc conversion result input
   input  wire logic [9:0]  adc_result_i,
   input  wire logic        adc_valid_i,
   output logic             adc_ready_o,
   output logic [3:0]       adc_input_o,
   // register-file write stream
   output logic [11:0]      rf_addr_o,
   output logic [7:0]       rf_data_o,
   output logic             rf_valid_o,
   input  wire logic        rf_ready_i
);
   logic [7:0]  hi0_reg, hi0_next, hi1_reg, hi1_next;
   logic [7:0]  st0_reg, st0_next, st1_reg, st1_next;
   logic [7:0]  en0_reg, en0_next, en1_reg, en1_next;
   logic [7:0]  ct0_reg, ct0_next, ct1_reg, ct1_next;
   logic [7:0]  base_reg, base_next, actl_reg, actl_next;
   logic [31:0] rdata_reg, rdata_next;
   logic        ack_reg, ack_next;
   logic        wr_st0, wr_st1;
   logic        ld0_reg, ld0_next, ld1_reg, ld1_next;
   logic        stop0, stop1;
   logic [11:0] cur0, cur1;
   dag_chan_cfg_t cfg0, cfg1;

   // single-cycle wait then answer
   assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
   assign avs_readdata    = rdata_reg;
   assign avs_response    = 2'b00;
   assign wr_st0 = avs_write && ack_reg &&
                   avs_address == `DAG_OFS_CH0_START_LOW;
   assign wr_st1 = avs_write && ack_reg &&
                   avs_address == `DAG_OFS_CH1_START_LOW;

   // channel configuration assembly
   always_comb begin
      cfg0.start_addr = {hi0_reg[3:0], st0_reg};
      cfg0.end_addr   = {hi0_reg[7:4], en0_reg};
      cfg0.en         = ct0_reg[`DAG_CTRL_EN_BIT];
      cfg0.loop       = ct0_reg[`DAG_CTRL_LOOP_BIT];
      cfg0.word       = ct0_reg[`DAG_CTRL_WORD_BIT];
      cfg1.start_addr = {hi1_reg[3:0], st1_reg};
      cfg1.end_addr   = {hi1_reg[7:4], en1_reg};
      cfg1.en         = ct1_reg[`DAG_CTRL_EN_BIT];
      cfg1.loop       = ct1_reg[`DAG_CTRL_LOOP_BIT];
      cfg1.word       = ct1_reg[`DAG_CTRL_WORD_BIT];
   end

   // current address loads one cycle after the start byte lands, so
   // it picks up the written byte; a read in that cycle sees the old one
   dag_chan_addr u_ch0 (
      .clk_i      (clk_i),
      .rst_b_i    (rst_b_i),
      .cfg_i      (cfg0),
      .start_wr_i (ld0_reg),
      .done_i     (ch0_done_i && cfg0.en),
      .cur_addr_o (cur0),
      .last_o     (),
      .stop_o     (stop0)
   );
   dag_chan_addr u_ch1 (
      .clk_i      (clk_i),
      .rst_b_i    (rst_b_i),
      .cfg_i      (cfg1),
      .start_wr_i (ld1_reg),
      .done_i     (ch1_done_i && cfg1.en),
      .cur_addr_o (cur1),
      .last_o     (),
      .stop_o     (stop1)
   );
   assign ch0_addr_o   = cur0;
   assign ch1_addr_o   = cur1;
   assign ch0_active_o = cfg0.en;
   assign ch1_active_o = cfg1.en;

   // register writes, reads and enable clear on end
   always_comb begin
      hi0_next = hi0_reg;
      hi1_next = hi1_reg;
      st0_next = st0_reg;
      st1_next = st1_reg;
      en0_next = en0_reg;
      en1_next = en1_reg;
      ct0_next = ct0_reg;
      ct1_next = ct1_reg;
      base_next = base_reg;
      actl_next = actl_reg;
      rdata_next = rdata_reg;
      ack_next = (avs_read || avs_write) && !ack_reg;
      ld0_next = wr_st0;
      ld1_next = wr_st1;
      if (avs_write && ack_reg) begin
         unique case (avs_address)
            `DAG_OFS_CH0_HIGH_NIB:  hi0_next  = avs_writedata[7:0];
            `DAG_OFS_CH0_START_LOW: st0_next  = avs_writedata[7:0];
            `DAG_OFS_CH0_END_LOW:   en0_next  = avs_writedata[7:0];
            `DAG_OFS_CH1_HIGH_NIB:  hi1_next  = avs_writedata[7:0];
            `DAG_OFS_CH1_START_LOW: st1_next  = avs_writedata[7:0];
            `DAG_OFS_CH1_END_LOW:   en1_next  = avs_writedata[7:0];
            `DAG_OFS_CH0_CTRL:      ct0_next  = avs_writedata[7:0];
            `DAG_OFS_CH1_CTRL:      ct1_next  = avs_writedata[7:0];
            `DAG_OFS_ADC_BASE:      base_next = avs_writedata[7:0];
            `DAG_OFS_ADC_CTRL:      actl_next = avs_writedata[7:0];
            default: ;
         endcase
      end
      // hardware stop wins over a software write in the same cycle
      if (stop0) ct0_next[`DAG_CTRL_EN_BIT] = 1'b0;
      if (stop1) ct1_next[`DAG_CTRL_EN_BIT] = 1'b0;
      if (avs_read && !ack_reg) begin
         rdata_next = 32'h0000_0000;
         unique case (avs_address)
            `DAG_OFS_CH0_HIGH_NIB:  rdata_next[7:0] = hi0_reg;
            `DAG_OFS_CH0_START_LOW: rdata_next[7:0] = cur0[7:0];
            `DAG_OFS_CH0_END_LOW:   rdata_next[7:0] = en0_reg;
            `DAG_OFS_CH1_HIGH_NIB:  rdata_next[7:0] = hi1_reg;
            `DAG_OFS_CH1_START_LOW: rdata_next[7:0] = cur1[7:0];
            `DAG_OFS_CH1_END_LOW:   rdata_next[7:0] = en1_reg;
            `DAG_OFS_CH0_CTRL:      rdata_next[7:0] = ct0_reg;
            `DAG_OFS_CH1_CTRL:      rdata_next[7:0] = ct1_reg;
            `DAG_OFS_ADC_BASE:      rdata_next[7:0] = base_reg;
            `DAG_OFS_ADC_CTRL:      rdata_next[7:0] = actl_reg;
            default:                rdata_next = 32'h0000_0000;
         endcase
      end
   end

   // register file state
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         hi0_reg <= `DAG_RESET_BYTE;
         hi1_reg <= `DAG_RESET_BYTE;
         st0_reg <= `DAG_RESET_BYTE;
         st1_reg <= `DAG_RESET_BYTE;
         en0_reg <= `DAG_RESET_BYTE;
         en1_reg <= `DAG_RESET_BYTE;
         ct0_reg <= `DAG_RESET_BYTE;
         ct1_reg <= `DAG_RESET_BYTE;
         base_reg <= `DAG_RESET_BYTE;
         actl_reg <= `DAG_RESET_BYTE;
         rdata_reg <= 32'h0000_0000;
         ack_reg <= 1'b0;
         ld0_reg <= 1'b0;
         ld1_reg <= 1'b0;
      end else begin
         hi0_reg <= hi0_next;
         hi1_reg <= hi1_next;
         st0_reg <= st0_next;
         st1_reg <= st1_next;
         en0_reg <= en0_next;
         en1_reg <= en1_next;
         ct0_reg <= ct0_next;
         ct1_reg <= ct1_next;
         base_reg <= base_next;
         actl_reg <= actl_next;
         rdata_reg <= rdata_next;
         ack_reg <= ack_next;
         ld0_reg <= ld0_next;
         ld1_reg <= ld1_next;
      end
   end

   // adc result path
   dag_adc_state_t st_reg, st_next;
   logic [3:0]  in_reg, in_next;
   logic [9:0]  res_reg, res_next;
   logic [3:0]  last_in;
   logic        adc_en;
   dag_xfer_t   buf_in;
   logic        buf_valid, buf_ready;
   dag_xfer_t   buf_out;

   assign adc_en  = actl_reg[`DAG_ADC_EN_BIT];
   assign last_in = (actl_reg[3:0] > `DAG_ADC_LAST_MAX) ? `DAG_ADC_LAST_MAX
                                                        : actl_reg[3:0];
   assign adc_ready_o = (st_reg == DAG_IDLE) && adc_en;
   assign adc_input_o = in_reg;
   assign buf_valid   = (st_reg != DAG_IDLE);
   // base bits 7..1, input number, then byte select
   always_comb begin
      buf_in.addr = {base_reg[7:1], in_reg,
                     (st_reg == DAG_LSB)};
      buf_in.data = (st_reg == DAG_MSB) ? {6'b00_0000, res_reg[9:8]}
                                        : res_reg[7:0];
      buf_in.ch   = 1'b0;
   end

   // adc sequence next state
   always_comb begin
      st_next  = st_reg;
      in_next  = in_reg;
      res_next = res_reg;
      unique case (st_reg)
         DAG_IDLE: begin
            if (adc_valid_i && adc_en) begin
               res_next = adc_result_i;
               st_next  = DAG_MSB;
            end
         end
         DAG_MSB: begin
            if (buf_ready) st_next = DAG_LSB;
         end
         DAG_LSB: begin
            if (buf_ready) begin
               st_next = DAG_IDLE;
               in_next = (in_reg >= last_in) ? 4'h0 : in_reg + 4'h1;
            end
         end
         default: st_next = DAG_IDLE;
      endcase
      if (!adc_en) in_next = 4'h0;
   end

   // adc sequence registers
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st_reg  <= DAG_IDLE;
         in_reg  <= 4'h0;
         res_reg <= 10'h000;
      end else begin
         st_reg  <= st_next;
         in_reg  <= in_next;
         res_reg <= res_next;
      end
   end

   dag_skid_buf u_buf (
      .clk_i       (clk_i),
      .rst_b_i     (rst_b_i),
      .in_data_i   (buf_in),
      .in_valid_i  (buf_valid),
      .in_ready_o  (buf_ready),
      .out_data_o  (buf_out),
      .out_valid_o (rf_valid_o),
      .out_ready_i (rf_ready_i)
   );
   assign rf_addr_o = buf_out.addr;
   assign rf_data_o = buf_out.data;

   // adc byte addresses and pairing
   chk_adc_msb_even: assert property (
      @(posedge clk_i) disable iff (!rst_b_i)
      st_reg == DAG_MSB |-> buf_in.addr ==
         {base_reg[7:1], in_reg, 1'b0})
      else $error("adc msb address wrong");
   chk_adc_pair: assert property (
      @(posedge clk_i) disable iff (!rst_b_i)
      st_reg == DAG_MSB && buf_ready |=> st_reg == DAG_LSB &&
         buf_in.addr == $past(buf_in.addr) + 12'h001)
      else $error("lsb not at following odd address");

   // msb byte queued, then the low byte at the odd address
   sequence s_msb_push;
      st_reg == DAG_MSB && buf_ready;
   endsequence
   sequence s_lsb_push;
      st_reg == DAG_LSB && buf_in.addr[0] && buf_in.data == res_reg[7:0];
   endsequence
   chk_adc_lsb_next: assert property (
      @(posedge clk_i) disable iff (!rst_b_i)
      s_msb_push |=> s_lsb_push)
      else $error("lsb byte did not follow msb byte");

   // a stalled byte stays put until the register file takes it
   chk_rf_hold: assert property (
      @(posedge clk_i) disable iff (!rst_b_i)
      rf_valid_o && !rf_ready_i |=> rf_valid_o && $stable(rf_addr_o) &&
         $stable(rf_data_o))
      else $error("stalled register-file byte changed");

   // adc input number stepping, wrapping and clearing
   chk_adc_input_wrap: assert property (
      @(posedge clk_i) disable iff (!rst_b_i)
      st_reg == DAG_LSB && buf_ready && in_reg >= last_in && adc_en
         |=> in_reg == 4'h0)
      else $error("adc input did not wrap");
   chk_adc_input_step: assert property (
      @(posedge clk_i) disable iff (!rst_b_i)
      st_reg == DAG_LSB && buf_ready && in_reg < last_in && adc_en
         |=> adc_input_o == $past(in_reg) + 4'h1)
      else $error("adc input did not step");
   chk_adc_off_clear: assert property (
      @(posedge clk_i) disable iff (!rst_b_i)
      !adc_en |=> adc_input_o == 4'h0)
      else $error("adc input not cleared while disabled");

   // start readback, loads and end stop
   chk_start_read: assert property (
      @(posedge clk_i) disable iff (!rst_b_i)
      avs_read && !ack_reg && avs_address == `DAG_OFS_CH0_START_LOW
         |=> avs_readdata[7:0] == $past(cur0[7:0]))
      else $error("start read not current address");
   chk_start_read1: assert property (
      @(posedge clk_i) disable iff (!rst_b_i)
      avs_read && !ack_reg && avs_address == `DAG_OFS_CH1_START_LOW
         |=> avs_readdata[7:0] == $past(cur1[7:0]))
      else $error("channel 1 start read not current address");
   chk_chan_stop: assert property (
      @(posedge clk_i) disable iff (!rst_b_i)
      stop0 |=> !ct0_reg[`DAG_CTRL_EN_BIT])
      else $error("channel not stopped at end");
   chk_start_load: assert property (
      @(posedge clk_i) disable iff (!rst_b_i)
      wr_st0 |=> st0_reg == $past(avs_writedata[7:0]))
      else $error("start write not loaded");
   chk_cur_load0: assert property (
      @(posedge clk_i) disable iff (!rst_b_i)
      wr_st0 |-> ##2 cur0[7:0] == $past(avs_writedata[7:0], 2))
      else $error("current address not loaded from start write");
   chk_cur_load1: assert property (
      @(posedge clk_i) disable iff (!rst_b_i)
      wr_st1 |-> ##2 cur1[7:0] == $past(avs_writedata[7:0], 2))
      else $error("channel 1 current address not loaded");
endmodule : dag_top

// File: dag_top_tb.sv
// self-checking bench for dma address generation
`timescale 1ns/100ps
`include "dag_consts.svh"
module dag_top_tb;
   logic        clk_i = 1'b0;
   logic        rst_b_i = 1'b0;
   logic [11:0] avs_address = 12'h000;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic [1:0]  avs_response;
   logic [3:0]  adc_input_o;
   logic        ch0_done_i = 1'b0;
   logic        ch1_done_i = 1'b0;
   logic [11:0] ch0_addr_o, ch1_addr_o;
   logic        ch0_active_o, ch1_active_o;
   logic [9:0]  adc_result_i = 10'h000;
   logic        adc_valid_i = 1'b0;
   logic        adc_ready_o;
   logic [11:0] rf_addr_o;
   logic [7:0]  rf_data_o;
   logic        rf_valid_o, rf_ready_i;
   logic        stall = 1'b0;
   int          miscompares = 0;
   int          n_tests = 0;

   always #50 clk_i = ~clk_i;

   dag_top dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
      .ch0_done_i(ch0_done_i), .ch1_done_i(ch1_done_i),
      .ch0_addr_o(ch0_addr_o), .ch1_addr_o(ch1_addr_o),
      .ch0_active_o(ch0_active_o), .ch1_active_o(ch1_active_o),
      .adc_result_i(adc_result_i), .adc_valid_i(adc_valid_i),
      .adc_ready_o(adc_ready_o), .adc_input_o(adc_input_o),
      .rf_addr_o(rf_addr_o),
      .rf_data_o(rf_data_o), .rf_valid_o(rf_valid_o),
      .rf_ready_i(rf_ready_i));

   dag_rf_sink sink (.clk_i(clk_i), .rst_b_i(rst_b_i), .stall_i(stall),
      .rf_addr_i(rf_addr_o), .rf_data_i(rf_data_o),
      .rf_valid_i(rf_valid_o), .rf_ready_o(rf_ready_i));

   // verdict and end of run
   task stop_test;
      $display("checks %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : stop_test

   // compare one value
   task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   // wait for waitrequest low at a rising edge, bounded
   task wait_ack;
      int i;
      for (i = 0; i < 50; i++) begin
         @(posedge clk_i);
         if (avs_waitrequest === 1'b0) break;
      end
      if (i == 50) begin
         miscompares++;
         stop_test();
      end
   endtask : wait_ack

   // avalon write of one register
   task bus_wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge clk_i);
      avs_address <= a;
      avs_writedata <= {24'h00_0000, d};
      avs_write <= 1'b1;
      wait_ack();
      avs_write <= 1'b0;
   endtask : bus_wr

   // avalon read of one register
   task bus_rd(input logic [11:0] a, output logic [7:0] d);
      @(posedge clk_i);
      avs_address <= a;
      avs_read <= 1'b1;
      wait_ack();
      d = avs_readdata[7:0];
      chk("response", 32'h0, {30'h0, avs_response});
      avs_read <= 1'b0;
   endtask : bus_rd

   // one-cycle completion strobe, then let the update land
   task pulse(input logic ch);
      @(posedge clk_i);
      if (ch) ch1_done_i <= 1'b1;
      else ch0_done_i <= 1'b1;
      @(posedge clk_i);
      ch0_done_i <= 1'b0;
      ch1_done_i <= 1'b0;
      @(posedge clk_i);
   endtask : pulse

   // register layout, readback and an unmapped place
   task t_regs;
      logic [7:0] d;
      bus_wr(`DAG_OFS_CH0_HIGH_NIB, 8'h21);
      bus_wr(`DAG_OFS_CH0_START_LOW, 8'hfe);
      bus_wr(`DAG_OFS_CH0_END_LOW, 8'h00);
      bus_rd(`DAG_OFS_CH0_START_LOW, d);
      chk("start_low", 32'h0000_00fe, {24'h0, d});
      bus_rd(`DAG_OFS_CH0_HIGH_NIB, d);
      chk("high_nib", 32'h0000_0021, {24'h0, d});
      chk("ch0_addr", 32'h0000_01fe, {20'h0, ch0_addr_o});
      bus_wr(`DAG_OFS_ADC_BASE, 8'h72);
      bus_rd(`DAG_OFS_ADC_BASE, d);
      chk("adc_base", 32'h0000_0072, {24'h0, d});
      bus_wr(12'h100, 8'h5a);
      bus_rd(12'h100, d);
      chk("unmapped", 32'h0000_0000, {24'h0, d});
      $display("test regs done");
   endtask : t_regs

   // byte steps across a nibble carry, end, reload and stop
   task t_byte;
      logic [7:0] d;
      bus_wr(`DAG_OFS_CH0_CTRL, 8'h80);
      @(posedge clk_i);
      chk("ch0_active", 32'h1, {31'h0, ch0_active_o});
      pulse(1'b0);
      chk("ch0_step1", 32'h0000_01ff, {20'h0, ch0_addr_o});
      pulse(1'b0);
      chk("ch0_step2", 32'h0000_0200, {20'h0, ch0_addr_o});
      pulse(1'b0);
      chk("ch0_reload", 32'h0000_01fe, {20'h0, ch0_addr_o});
      chk("ch0_stop", 32'h0, {31'h0, ch0_active_o});
      pulse(1'b0);
      chk("ch0_idle", 32'h0000_01fe, {20'h0, ch0_addr_o});
      bus_rd(`DAG_OFS_CH0_START_LOW, d);
      chk("ch0_rd", 32'h0000_00fe, {24'h0, d});
      $display("test byte done");
   endtask : t_byte

   // word steps with looping on channel 1
   task t_word;
      logic [7:0] d;
      bus_wr(`DAG_OFS_CH1_HIGH_NIB, 8'h00);
      bus_wr(`DAG_OFS_CH1_START_LOW, 8'h10);
      bus_wr(`DAG_OFS_CH1_END_LOW, 8'h14);
      bus_wr(`DAG_OFS_CH1_CTRL, 8'hc8);
      pulse(1'b1);
      chk("ch1_step1", 32'h0000_0012, {20'h0, ch1_addr_o});
      bus_rd(`DAG_OFS_CH1_START_LOW, d);
      chk("ch1_rd", 32'h0000_0012, {24'h0, d});
      pulse(1'b1);
      chk("ch1_end", 32'h0000_0014, {20'h0, ch1_addr_o});
      pulse(1'b1);
      chk("ch1_reload", 32'h0000_0010, {20'h0, ch1_addr_o});
      chk("ch1_loop", 32'h1, {31'h0, ch1_active_o});
      $display("test word done");
   endtask : t_word

   // three adc results into a stalling register file
   task t_adc;
      logic [9:0]  res [3];
      logic [11:0] a;
      int          i, j;
      res = '{10'h3a5, 10'h155, 10'h2c3};
      stall <= 1'b1;
      bus_wr(`DAG_OFS_ADC_CTRL, 8'h82);
      for (i = 0; i < 3; i++) begin
         @(posedge clk_i);
         adc_result_i <= res[i];
         adc_valid_i <= 1'b1;
         for (j = 0; j < 100; j++) begin
            @(posedge clk_i);
            if (adc_ready_o === 1'b1) break;
         end
         if (j == 100) begin
            miscompares++;
            stop_test();
         end
         adc_valid_i <= 1'b0;
      end
      repeat (4) @(posedge clk_i);
      for (j = 0; j < 100; j++) begin
         @(posedge clk_i);
         if (rf_valid_o === 1'b0) break;
      end
      chk("rf_drained", 32'h0, {31'h0, rf_valid_o});
      chk("adc_input", 32'h0, {28'h0, adc_input_o});
      for (i = 0; i < 3; i++) begin
         a = {7'h39, i[3:0], 1'b0};
         chk("rf_msb", {30'h0, res[i][9:8]}, {24'h0, sink.mem[a]});
         a = a + 12'h001;
         chk("rf_lsb", {24'h0, res[i][7:0]}, {24'h0, sink.mem[a]});
      end
      stall <= 1'b0;
      $display("test adc done");
   endtask : t_adc

   // reset, then the scenarios in turn
   initial begin
      repeat (5) @(posedge clk_i);
      rst_b_i <= 1'b1;
      t_regs();
      t_byte();
      t_word();
      t_adc();
      stop_test();
   end
endmodule : dag_top_tb
